/* logic/nv_seq_pkg.sv */
// Package with register map, field layout and timing for the EEPROM sequencer
package nv_seq_pkg;
   // APB byte offsets
   localparam logic [7:0] ADDR_OFF = 8'h00;
   localparam logic [7:0] DATA_OFF = 8'h04;
   localparam logic [7:0] PTRL_OFF = 8'h08;
   localparam logic [7:0] PTRH_OFF = 8'h0C;
   localparam logic [7:0] PORT_OFF = 8'h10;
   localparam logic [7:0] STAT_OFF = 8'h14;
   localparam logic [7:0] MASK_OFF = 8'h18;
   localparam logic [7:0] POWER_OFF = 8'h1C;
   // Indirect location of the control register
   localparam logic [7:0] CTRL_PTRL = 8'h40;
   localparam logic [7:0] CTRL_PTRH = 8'h01;
   // Control register field positions
   localparam int FETCH_START_BIT = 0;
   localparam int FETCH_ENABLE_BIT = 1;
   localparam int PROG_START_BIT = 2;
   localparam int PROG_ENABLE_BIT = 3;
   // Status bit positions
   localparam int DONE_BIT = 0;
   localparam int FAIL_BIT = 1;
   // Geometry
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int DEPTH = 64;
   // Reset values
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // Timing: clock and internal write time
   localparam int CLK_MHZ = 250;
   localparam int READ_CYC = 2;
   localparam int PROG_TIME_US = 20;
   localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
   // Sequencer states
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_PROG = 2'b10
   } seq_state_e;
endpackage

/* logic/nv_cycle_timer.sv */
// Down counter that times one memory access cycle
`timescale 1ns/1ps
module nv_cycle_timer #(
   parameter int W = 16
) (
   input wire logic clk_i, // System clock
   input wire logic sys_rst_i, // Synchronous reset
   input wire logic load_i, // Load a new count
   input wire logic abort_i, // Stop counting
   input wire logic [W-1:0] count_i, // Cycles to time
   output logic done_o // Pulse when count expires
);
   typedef struct packed
   {
      logic [W-1:0] cnt;
      logic run;
      logic done;
   } tmr_s;
   tmr_s st_r;
   tmr_s st_nxt;

   // Count down while running, pulse done when the count reaches one
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (load_i)
      begin
         st_nxt.cnt = count_i;
         st_nxt.run = 1'b1;
      end
      else if (abort_i)
      begin
         st_nxt.run = 1'b0;
      end
      else if (st_r.run)
      begin
         if (st_r.cnt <= W'(1))
         begin
            st_nxt.run = 1'b0;
            st_nxt.done = 1'b1;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt - W'(1);
         end
      end
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign done_o = st_r.done;
endmodule

/* logic/nv_byte_store.sv */
// Flip-flop byte array holding the nonvolatile data
`timescale 1ns/1ps
module nv_byte_store #(
   parameter int AW = 6,
   parameter int DW = 8,
   parameter int N = 64
) (
   input wire logic clk_i, // System clock
   input wire logic sys_rst_i, // Synchronous reset
   input wire logic we_i, // Commit one byte
   input wire logic [AW-1:0] addr_i, // Byte index
   input wire logic [DW-1:0] wdata_i, // Byte to store
   output logic [DW-1:0] rdata_o // Registered byte read
);
   typedef struct packed
   {
      logic [N-1:0][DW-1:0] mem;
      logic [DW-1:0] rd;
   } store_s;
   store_s st_r;
   store_s st_nxt;

   // One byte per access
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rd = st_r.mem[addr_i];
      if (we_i)
         st_nxt.mem[addr_i] = wdata_i;
   end

   // Contents model erased-to-zero memory at reset
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign rdata_o = st_r.rd;
endmodule

/* logic/nv_access_seq.sv */
// Data EEPROM access sequencer with APB registers and done interrupt
// Notes on behaviour
// - Entering idle or sleep during a pending access makes it fail.
// - Control register reached via pointer low 40H, high 01H, indirect port.
// - Hardware clears fetch start when the read ends.
// - Hardware clears program start when the write finishes.
// - Start bits act only when their enable bit is already set.
// - Write end sets sticky done flag and a pulsed multi-function flag.
// - Memory is 64 bytes with a six-bit address, one byte per access.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module nv_access_seq #(
   parameter int PROG_CYCLES = nv_seq_pkg::PROG_CYC // Write time in clocks
) (
   input wire logic clk_i, // System clock
   input wire logic sys_rst_i, // Synchronous reset
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   output logic irq_o, // Level interrupt
   output logic mf_flag_o // Multi-function request pulse
);
   localparam int TW = 16;

   typedef struct packed
   {
      nv_seq_pkg::seq_state_e state;
      logic [nv_seq_pkg::ADDR_W-1:0] nv_byte_address;
      logic [nv_seq_pkg::DATA_W-1:0] nv_byte_value;
      logic [7:0] pointer_low_byte;
      logic [7:0] pointer_high_byte;
      logic [3:0] nv_control;
      logic [1:0] status;
      logic [1:0] mask;
      logic low_power;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic irq;
      logic mf;
   } seq_s;
   seq_s st_r;
   seq_s st_nxt;

   logic tmr_load;
   logic [TW-1:0] tmr_count;
   logic tmr_done;
   logic mem_we;
   logic [nv_seq_pkg::DATA_W-1:0] mem_rdata;
   logic setup;
   logic wr_acc;
   logic ctrl_sel;
   logic [3:0] wc;
   logic start_fetch;
   logic start_prog;
   logic abort;

   // Access decode; control register only through the indirect port
   always_comb
   begin
      setup = psel && !penable;
      wr_acc = setup && pwrite;
      ctrl_sel = (st_r.pointer_low_byte == nv_seq_pkg::CTRL_PTRL) &&
         (st_r.pointer_high_byte == nv_seq_pkg::CTRL_PTRH);
      wc = pwdata[3:0];
      start_fetch = wr_acc && (paddr == nv_seq_pkg::PORT_OFF) && ctrl_sel &&
         wc[nv_seq_pkg::FETCH_START_BIT] &&
         st_r.nv_control[nv_seq_pkg::FETCH_ENABLE_BIT] &&
         (st_r.state == nv_seq_pkg::ST_IDLE);
      start_prog = wr_acc && (paddr == nv_seq_pkg::PORT_OFF) && ctrl_sel &&
         wc[nv_seq_pkg::PROG_START_BIT] &&
         st_r.nv_control[nv_seq_pkg::PROG_ENABLE_BIT] &&
         (st_r.state == nv_seq_pkg::ST_IDLE) && !start_fetch;
      abort = st_r.low_power && (st_r.state != nv_seq_pkg::ST_IDLE);
      tmr_load = start_fetch || start_prog;
      tmr_count = start_prog ? TW'(PROG_CYCLES) : TW'(nv_seq_pkg::READ_CYC);
   end

   // Registers, sequencer and interrupt logic
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.ready = 1'b0;
      st_nxt.err = 1'b0;
      st_nxt.mf = 1'b0;
      mem_we = 1'b0;
      // Software register writes
      if (wr_acc)
      begin
         unique case (paddr)
            nv_seq_pkg::ADDR_OFF: st_nxt.nv_byte_address = pwdata[nv_seq_pkg::ADDR_W-1:0];
            nv_seq_pkg::DATA_OFF: st_nxt.nv_byte_value = pwdata[nv_seq_pkg::DATA_W-1:0];
            nv_seq_pkg::PTRL_OFF: st_nxt.pointer_low_byte = pwdata[7:0];
            nv_seq_pkg::PTRH_OFF: st_nxt.pointer_high_byte = pwdata[7:0];
            nv_seq_pkg::PORT_OFF:
            begin
               if (ctrl_sel)
               begin
                  st_nxt.nv_control[nv_seq_pkg::FETCH_ENABLE_BIT] =
                     wc[nv_seq_pkg::FETCH_ENABLE_BIT];
                  st_nxt.nv_control[nv_seq_pkg::PROG_ENABLE_BIT] =
                     wc[nv_seq_pkg::PROG_ENABLE_BIT];
                  // Start bits only rise through a taken start; busy bits hold
                  if (st_r.state == nv_seq_pkg::ST_IDLE)
                  begin
                     st_nxt.nv_control[nv_seq_pkg::FETCH_START_BIT] = start_fetch;
                     st_nxt.nv_control[nv_seq_pkg::PROG_START_BIT] = start_prog;
                  end
               end
            end
            nv_seq_pkg::STAT_OFF: st_nxt.status = st_r.status & ~pwdata[1:0];
            nv_seq_pkg::MASK_OFF: st_nxt.mask = pwdata[1:0];
            nv_seq_pkg::POWER_OFF: st_nxt.low_power = pwdata[0];
            default: st_nxt.err = 1'b1;
         endcase
      end
      // Launch
      if (start_fetch)
         st_nxt.state = nv_seq_pkg::ST_READ;
      else if (start_prog)
         st_nxt.state = nv_seq_pkg::ST_PROG;
      // Low power kills a pending cycle
      if (abort)
      begin
         st_nxt.state = nv_seq_pkg::ST_IDLE;
         st_nxt.nv_control[nv_seq_pkg::FETCH_START_BIT] = 1'b0;
         st_nxt.nv_control[nv_seq_pkg::PROG_START_BIT] = 1'b0;
         st_nxt.status[nv_seq_pkg::FAIL_BIT] = 1'b1;
      end
      else if (tmr_done)
      begin
         unique case (st_r.state)
            nv_seq_pkg::ST_READ:
            begin
               st_nxt.nv_byte_value = mem_rdata;
               st_nxt.nv_control[nv_seq_pkg::FETCH_START_BIT] = 1'b0;
            end
            nv_seq_pkg::ST_PROG:
            begin
               mem_we = 1'b1;
               st_nxt.nv_control[nv_seq_pkg::PROG_START_BIT] = 1'b0;
               st_nxt.status[nv_seq_pkg::DONE_BIT] = 1'b1;
               st_nxt.mf = 1'b1;
            end
            default: ;
         endcase
         st_nxt.state = nv_seq_pkg::ST_IDLE;
      end
      // Read data
      st_nxt.rdata = '0;
      if (setup && !pwrite)
      begin
         unique case (paddr)
            nv_seq_pkg::ADDR_OFF: st_nxt.rdata = 32'(st_r.nv_byte_address);
            nv_seq_pkg::DATA_OFF: st_nxt.rdata = 32'(st_r.nv_byte_value);
            nv_seq_pkg::PTRL_OFF: st_nxt.rdata = 32'(st_r.pointer_low_byte);
            nv_seq_pkg::PTRH_OFF: st_nxt.rdata = 32'(st_r.pointer_high_byte);
            nv_seq_pkg::PORT_OFF: st_nxt.rdata = ctrl_sel ? 32'(st_r.nv_control) : 32'h0;
            nv_seq_pkg::STAT_OFF: st_nxt.rdata = 32'(st_r.status);
            nv_seq_pkg::MASK_OFF: st_nxt.rdata = 32'(st_r.mask);
            nv_seq_pkg::POWER_OFF: st_nxt.rdata = 32'(st_r.low_power);
            default: st_nxt.err = 1'b1;
         endcase
      end
      st_nxt.ready = setup;
      st_nxt.irq = |(st_nxt.status & st_nxt.mask);
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // Access cycle timer for reads and writes
   nv_cycle_timer #(.W(TW)) u_timer (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(tmr_load),
      .abort_i(abort),
      .count_i(tmr_count),
      .done_o(tmr_done)
   );

   // Byte array
   nv_byte_store #(
      .AW(nv_seq_pkg::ADDR_W),
      .DW(nv_seq_pkg::DATA_W),
      .N(nv_seq_pkg::DEPTH)
   ) u_store (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .we_i(mem_we),
      .addr_i(st_r.nv_byte_address),
      .wdata_i(st_r.nv_byte_value),
      .rdata_o(mem_rdata)
   );

   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.err;
   assign irq_o = st_r.irq;
   assign mf_flag_o = st_r.mf;

   // Assertions
   sequence prog_launch_s;
      start_prog;
   endsequence
   sequence prog_end_s;
      !st_r.nv_control[nv_seq_pkg::PROG_START_BIT];
   endsequence

   no_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.state == nv_seq_pkg::ST_IDLE && !st_r.nv_control[nv_seq_pkg::PROG_ENABLE_BIT])
      |=> st_r.state != nv_seq_pkg::ST_PROG)
      else $error("Write started without enable");
   prog_busy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      prog_launch_s |=> st_r.nv_control[nv_seq_pkg::PROG_START_BIT])
      else $error("Write start bit not set at launch");
   prog_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.state == nv_seq_pkg::ST_PROG && tmr_done && !abort) |=> prog_end_s)
      else $error("Write start bit not cleared at end");
   read_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (start_fetch && !st_r.low_power) |=> ##[1:4]
      !st_r.nv_control[nv_seq_pkg::FETCH_START_BIT])
      else $error("Read start bit stuck");
   done_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.state == nv_seq_pkg::ST_PROG && tmr_done && !abort)
      |=> st_r.status[nv_seq_pkg::DONE_BIT] && mf_flag_o)
      else $error("Done flags not raised");
   fail_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      abort |=> st_r.state == nv_seq_pkg::ST_IDLE && st_r.status[nv_seq_pkg::FAIL_BIT])
      else $error("Low power did not fail cycle");
   fail_nowrite_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      abort |-> !mem_we)
      else $error("Write committed in low power");
   ctrl_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (wr_acc && paddr == nv_seq_pkg::PORT_OFF && !ctrl_sel) |=> $stable(st_r.nv_control[3])
         && $stable(st_r.nv_control[1]))
      else $error("Control changed without pointer");
   read_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.state == nv_seq_pkg::ST_READ && tmr_done && !abort)
      |=> st_r.nv_byte_value == $past(mem_rdata))
      else $error("Read data not loaded");
endmodule

/* verif/nv_cpu_model.sv */
// CPU bus master model running the access program over APB
`timescale 1ns/1ps
module nv_cpu_model (
   input wire logic clk_i, // System clock
   output logic psel, // APB select
   output logic penable, // APB enable
   output logic pwrite, // APB direction
   output logic [7:0] paddr, // APB byte address
   output logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr // APB error
);
   int hangs = 0;
   logic global_irq_enable = 1'b1;
   logic [31:0] rd;
   logic err;
   // Bus idle at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // One transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk_i);
         if (pready === 1'b1)
            break;
      end
      if (n == 50)
         hangs++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a; // Released lines do not keep their value
      pwdata <= ~d;
   endtask
   // Aim the pointer at the control register
   task automatic point();
      apb(1'b1, nv_seq_pkg::PTRL_OFF, 32'(nv_seq_pkg::CTRL_PTRL));
      apb(1'b1, nv_seq_pkg::PTRH_OFF, 32'(nv_seq_pkg::CTRL_PTRH));
   endtask
   task automatic port(input logic [3:0] v);
      apb(1'b1, nv_seq_pkg::PORT_OFF, 32'(v));
   endtask
   // Poll a busy bit of the control register, bounded
   task automatic poll(input int b);
      int i;
      for (i = 0; i < 200; i++)
      begin
         apb(1'b0, nv_seq_pkg::PORT_OFF, 32'h0);
         if (rd[b] === 1'b0)
            break;
      end
      if (i == 200)
         hangs++;
   endtask
   // Disable access again after each cycle
   task automatic finish_acc();
      port(4'h0);
      apb(1'b1, nv_seq_pkg::PTRH_OFF, 32'h0);
   endtask
   // Write one byte, optionally dropping to low power mid-cycle
   task automatic write_byte(input logic [5:0] a, input logic [7:0] d, input logic nap);
      apb(1'b1, nv_seq_pkg::ADDR_OFF, 32'(a));
      apb(1'b1, nv_seq_pkg::DATA_OFF, 32'(d));
      point();
      global_irq_enable = 1'b0;
      port(4'h8);
      port(4'hC);
      global_irq_enable = 1'b1;
      if (nap)
         apb(1'b1, nv_seq_pkg::POWER_OFF, 32'h1);
      poll(nv_seq_pkg::PROG_START_BIT);
      apb(1'b1, nv_seq_pkg::POWER_OFF, 32'h0);
      finish_acc();
   endtask
   // Read one byte; the value is left in rd
   task automatic read_byte(input logic [5:0] a);
      apb(1'b1, nv_seq_pkg::ADDR_OFF, 32'(a));
      point();
      port(4'h2);
      port(4'h3);
      poll(nv_seq_pkg::FETCH_START_BIT);
      finish_acc();
      apb(1'b0, nv_seq_pkg::DATA_OFF, 32'h0);
   endtask
endmodule

/* verif/data_eeprom_access_sequencer_bench.sv */
// Self-checking bench for the EEPROM access sequencer
`timescale 1ns/1ps
module data_eeprom_access_sequencer_bench;
   typedef struct {logic [5:0] a; logic [7:0] d;} row_s;
   row_s rows [4] = '{'{6'h00, 8'hA5}, '{6'h3F, 8'h5A}, '{6'h01, 8'hFF}, '{6'h20, 8'h3C}};
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, irq_o, mf_flag_o;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   int err_count = 0;
   int samples_checked = 0;
   int mf_seen = 0;
   int i;
   // Clock and pulse counter
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i)
      if (mf_flag_o === 1'b1)
         mf_seen++;
   nv_cpu_model cpu (.clk_i(clk_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   nv_access_seq #(.PROG_CYCLES(20)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq_o(irq_o), .mf_flag_o(mf_flag_o));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      err_count += cpu.hangs;
      $display("Checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Overall run limit
   initial
   begin
      repeat (100000) @(posedge clk_i);
      err_count++;
      close_out();
   end
   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (i = 0; i < 8; i++)
      begin
         cpu.apb(1'b0, 8'(i * 4), 32'h0);
         check("reset value", cpu.rd, 32'h0);
      end
      check("irq after reset", {31'h0, irq_o}, 32'h0);
      // Ordinary cases: write every row, then read each back
      for (i = 0; i < 4; i++)
      begin
         cpu.write_byte(rows[i].a, rows[i].d, 1'b0);
         check("done pulses", mf_seen, i + 1);
      end
      for (i = 0; i < 4; i++)
      begin
         cpu.read_byte(rows[i].a);
         check("byte read", cpu.rd, 32'(rows[i].d));
      end
      // Sticky done flag, mask and interrupt
      cpu.apb(1'b0, nv_seq_pkg::STAT_OFF, 32'h0);
      check("done sticky", cpu.rd, 32'h1);
      check("irq masked", {31'h0, irq_o}, 32'h0);
      cpu.apb(1'b1, nv_seq_pkg::MASK_OFF, 32'h1);
      cpu.apb(1'b0, nv_seq_pkg::MASK_OFF, 32'h0);
      check("irq unmasked", {31'h0, irq_o}, 32'h1);
      cpu.apb(1'b1, nv_seq_pkg::STAT_OFF, 32'h1);
      cpu.apb(1'b0, nv_seq_pkg::STAT_OFF, 32'h0);
      check("done cleared", cpu.rd, 32'h0);
      check("irq cleared", {31'h0, irq_o}, 32'h0);
      // Unmapped offset
      cpu.apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      check("unmapped write err", {31'h0, cpu.err}, 32'h1);
      cpu.apb(1'b0, 8'h20, 32'h0);
      check("unmapped read err", {31'h0, cpu.err}, 32'h1);
      check("unmapped read", cpu.rd, 32'h0);
      // Port unreachable unless both pointer bytes select the control register
      cpu.apb(1'b1, nv_seq_pkg::PTRL_OFF, 32'h40);
      cpu.apb(1'b1, nv_seq_pkg::PTRH_OFF, 32'h0);
      cpu.port(4'h8);
      cpu.point();
      cpu.apb(1'b0, nv_seq_pkg::PORT_OFF, 32'h0);
      check("port off sector", cpu.rd, 32'h0);
      // Start bits without their enable do nothing
      cpu.port(4'h4);
      cpu.apb(1'b0, nv_seq_pkg::PORT_OFF, 32'h0);
      check("prog start alone", cpu.rd, 32'h0);
      cpu.port(4'h1);
      cpu.apb(1'b0, nv_seq_pkg::PORT_OFF, 32'h0);
      check("fetch start alone", cpu.rd, 32'h0);
      check("no cycle ran", mf_seen, 4);
      cpu.finish_acc();
      // Low power during a write: fails, byte kept, no done pulse
      cpu.write_byte(6'h05, 8'h77, 1'b1);
      cpu.apb(1'b0, nv_seq_pkg::STAT_OFF, 32'h0);
      check("fail flag", cpu.rd, 32'h2);
      check("no done pulse", mf_seen, 4);
      cpu.read_byte(6'h05);
      check("byte kept", cpu.rd, 32'h0);
      // Mid-run reset clears flags, interrupt and stored bytes
      cpu.apb(1'b1, nv_seq_pkg::MASK_OFF, 32'h3);
      check("irq on fail", {31'h0, irq_o}, 32'h1);
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      check("irq after mid reset", {31'h0, irq_o}, 32'h0);
      cpu.apb(1'b0, nv_seq_pkg::STAT_OFF, 32'h0);
      check("status after mid reset", cpu.rd, 32'h0);
      cpu.read_byte(6'h00);
      check("byte after mid reset", cpu.rd, 32'h0);
      close_out();
   end
endmodule
